// [dlst_pkg.sv]
// Package for the dead-link and lane-sync supervision block of one port pair
package dlst_pkg;
  localparam int          NUM_LANES      = 4;
  localparam int          NUM_PORTS      = 8;
  localparam int          LST_W          = 20;
  localparam logic [19:0] LST_LIMIT      = 20'hfffff;
  localparam int          DLT_W          = 24;
  localparam int          THR_W          = 3;
  localparam int          DLT_BASE_SHIFT = 10;
  localparam logic [2:0]  DLT_THR_RST    = 3'h3;
  localparam logic [1:0]  ADDR_CTRL      = 2'h0;
  localparam logic [1:0]  ADDR_STAT      = 2'h1;
  localparam logic [1:0]  ADDR_PORTNUM   = 2'h2;
  localparam int          CTRL_DEAD_LINK_TIMER_ENABLE    = 0;
  localparam int          CTRL_THR_LSB   = 1;
  localparam int          CTRL_PW_EN     = 4;
  localparam int          CTRL_MODE1X    = 5;
  localparam int          CTRL_ERR_CLR_E = 8;
  localparam int          CTRL_ERR_CLR_O = 9;

  typedef enum logic [1:0] {
    DLST_LINK_DOWN = 2'b00,
    DLST_LINK_UP   = 2'b01,
    DLST_DEAD      = 2'b10
  } dlst_link_t;

  typedef struct packed {
    logic             dltEn;
    logic [THR_W-1:0] dltThr;
    logic             pwEn;
    logic             mode1x;
  } dlst_cfg_t;

  typedef struct packed {
    dlst_link_t            link;
    logic [DLT_W-1:0]      dltCnt;
    logic [NUM_LANES-1:0]  lstRun;
    logic [NUM_LANES-1:0][LST_W-1:0] lstCnt;
    logic [1:0]            portErr;
    logic [1:0]            pwReq;
    logic [2:0]            symSync;
    logic [NUM_LANES-1:0][2:0] syncSh;
    logic                  symLvl;
    logic [NUM_LANES-1:0]  syncLvl;
    dlst_cfg_t             cfg;
    logic [31:0]           rdData;
  } dlst_state_t;
endpackage : dlst_pkg

// [dlst_pair.sv]
// Dead-link timer and per-lane lane-sync timers for one even/odd port pair
`timescale 1ns/1ps
`default_nettype none
module dlst_pair
  import dlst_pkg::*;
#(
  parameter int          LST_W_P  = LST_W,
  parameter logic [19:0] LST_MAX  = LST_LIMIT,
  parameter int          BASE_SH  = DLT_BASE_SHIFT,
  parameter logic [2:0]  PAIR_IDX = 3'h0
) (
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire logic                  symClk,
  input  wire logic [NUM_LANES-1:0]  laneSync,
  input  wire logic                  linkInitDone,
  input  wire logic [1:0]            regAddr,
  input  wire logic [31:0]           regWdata,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic      [31:0]           regRdata,
  input  wire logic                  fabTxValid,
  output logic                       fabTxReady,
  input  wire logic                  txPktValid,
  output logic                       txPktReady,
  input  wire logic                  rxPktValid,
  output logic                       rxFwdValid,
  output logic                       txFlush,
  output logic                       txFwdValid,
  output logic      [1:0]            portErr,
  output logic      [1:0]            portWriteReq,
  output logic      [NUM_LANES-1:0]  laneTxEnEven,
  output logic      [NUM_LANES-1:0]  laneTxEnOdd,
  output logic                       syncRestart,
  output logic                       ackTimerPause,
  output logic                       ttlTimerRun,
  output logic      [2:0]            evenPortNum,
  output logic      [2:0]            oddPortNum
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dlst_state_t st_ff;
  dlst_state_t nxt_st;

  wire logic [NUM_LANES-1:0] syncQ;
  logic                      symAgree;
  logic                      symTick;
  logic                      anyLoss;
  logic [DLT_W-1:0]          dltLimit;
  wire logic [NUM_LANES-1:0] lstExp;
  logic                      dltExp;
  logic [1:0]                errSet;
  logic [1:0]                errClr;

  always_comb begin
    // Symbol clock edge counts only once both later stages agree on high
    symAgree = (st_ff.symSync[1] == st_ff.symSync[2]);
    symTick  = symAgree && st_ff.symSync[2] && !st_ff.symLvl;
  end

  // ----------------------------------------------------------------
  // Per-lane input filter and lane timer expiry
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_LANES; g++) begin : gLane
    // A level change counts only once second and third stages agree
    assign syncQ[g]  = (st_ff.syncSh[g][1] == st_ff.syncSh[g][2]) ? st_ff.syncSh[g][2]
                                                                  : st_ff.syncLvl[g];
    assign lstExp[g] = st_ff.lstRun[g] && symTick
                       && (st_ff.lstCnt[g] == LST_W'(LST_MAX - 20'h1));
  end

  // ----------------------------------------------------------------
  // Lane ownership
  // ----------------------------------------------------------------
  logic [NUM_LANES-1:0] evenLanes;
  logic [NUM_LANES-1:0] oddLanes;

  always_comb begin
    if (st_ff.cfg.mode1x) begin
      evenLanes = 4'h1;
      oddLanes  = 4'h2;
    end else begin
      evenLanes = 4'hf;
      oddLanes  = 4'h0; // odd port keeps registers but no PHY
    end
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  // Power-of-two thresholds keep the compare cheap
  assign dltLimit = DLT_W'(1) << (BASE_SH + int'(st_ff.cfg.dltThr));

  always_comb begin
    anyLoss = |(~syncQ & (evenLanes | oddLanes));
    dltExp  = st_ff.cfg.dltEn && (st_ff.link == DLST_LINK_UP) && anyLoss
              && symTick && (st_ff.dltCnt >= dltLimit - DLT_W'(1));
  end

  always_comb begin
    errSet[0] = |(lstExp & evenLanes) | dltExp;
    errSet[1] = |(lstExp & oddLanes) | dltExp;
    if (st_ff.cfg.mode1x && |(lstExp & oddLanes)) begin
      errSet[0] = 1'b1;
    end
    errClr[0] = regWr && (regAddr == ADDR_CTRL) && regWdata[CTRL_ERR_CLR_E];
    errClr[1] = regWr && (regAddr == ADDR_CTRL) && regWdata[CTRL_ERR_CLR_O];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.symSync = {st_ff.symSync[1:0], symClk};
    nxt_st.symLvl  = symAgree ? st_ff.symSync[2] : st_ff.symLvl;
    nxt_st.syncLvl = syncQ;
    for (int i = 0; i < NUM_LANES; i++) begin
      nxt_st.syncSh[i] = {st_ff.syncSh[i][1:0], laneSync[i]};
    end
    nxt_st.pwReq = 2'h0;

    case (st_ff.link)
      DLST_LINK_DOWN: begin
        if (linkInitDone) begin
          nxt_st.link = DLST_LINK_UP;
        end
      end
      DLST_LINK_UP: begin
        if (dltExp) begin
          nxt_st.link = DLST_DEAD;
        end else if (!linkInitDone && !anyLoss) begin
          nxt_st.link = DLST_LINK_DOWN;
        end
      end
      DLST_DEAD: begin
        // Leaves only once all owned lanes are back in sync
        if (!anyLoss && linkInitDone) begin
          nxt_st.link = DLST_LINK_UP;
        end
      end
      default: nxt_st.link = DLST_LINK_DOWN;
    endcase

    if (!st_ff.cfg.dltEn || !anyLoss || st_ff.link != DLST_LINK_UP) begin
      nxt_st.dltCnt = '0;
    end else if (symTick) begin
      nxt_st.dltCnt = st_ff.dltCnt + DLT_W'(1);
    end

    for (int i = 0; i < NUM_LANES; i++) begin
      if (syncQ[i] || !(evenLanes[i] | oddLanes[i])) begin
        nxt_st.lstRun[i] = 1'b0;
        nxt_st.lstCnt[i] = '0;
      end else if (!st_ff.lstRun[i] && st_ff.link != DLST_LINK_DOWN) begin
        nxt_st.lstRun[i] = 1'b1;
      end else if (lstExp[i]) begin
        nxt_st.lstRun[i] = 1'b0;
        nxt_st.lstCnt[i] = '0;
      end else if (st_ff.lstRun[i] && symTick) begin
        nxt_st.lstCnt[i] = st_ff.lstCnt[i] + LST_W'(1);
      end
    end

    for (int p = 0; p < 2; p++) begin
      // Set beats clear in the same cycle
      if (errSet[p]) begin
        nxt_st.portErr[p] = 1'b1;
        nxt_st.pwReq[p]   = st_ff.cfg.pwEn && !st_ff.portErr[p];
      end else if (errClr[p]) begin
        nxt_st.portErr[p] = 1'b0;
      end
    end

    if (regWr && regAddr == ADDR_CTRL) begin
      nxt_st.cfg.dltEn  = regWdata[CTRL_DEAD_LINK_TIMER_ENABLE];
      nxt_st.cfg.dltThr = regWdata[CTRL_THR_LSB +: THR_W];
      nxt_st.cfg.pwEn   = regWdata[CTRL_PW_EN];
      nxt_st.cfg.mode1x = regWdata[CTRL_MODE1X];
    end

    nxt_st.rdData = 32'h0;
    if (regRd) begin
      case (regAddr)
        ADDR_CTRL: nxt_st.rdData = {26'h0, st_ff.cfg.mode1x, st_ff.cfg.pwEn,
                                    st_ff.cfg.dltThr, st_ff.cfg.dltEn};
        // Only the error flags reveal lane timer expiry
        ADDR_STAT: nxt_st.rdData = {28'h0, st_ff.link, st_ff.portErr};
        ADDR_PORTNUM: nxt_st.rdData = {24'h0, 1'b0, oddPortNum, 1'b0, evenPortNum};
        default: nxt_st.rdData = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '{link: DLST_LINK_DOWN, dltCnt: '0, lstRun: '0, lstCnt: '0,
                 // Lanes start at their idle in-sync level, so no false loss
                 portErr: 2'h0, pwReq: 2'h0, symSync: 3'h0, syncSh: '1,
                 symLvl: 1'b0, syncLvl: '1,
                 cfg: '{dltEn: 1'b1, dltThr: DLT_THR_RST, pwEn: 1'b0, mode1x: 1'b0},
                 rdData: 32'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic dead;
  assign dead         = (st_ff.link == DLST_DEAD);
  assign regRdata     = st_ff.rdData;
  assign portErr      = st_ff.portErr;
  assign portWriteReq = st_ff.pwReq;
  assign txFlush      = dead;
  assign txPktReady   = dead;                              // buffer drained
  assign fabTxReady   = 1'b1;                              // never stalls
  assign txFwdValid   = fabTxValid & ~dead;
  assign rxFwdValid   = rxPktValid;
  assign laneTxEnEven = evenLanes;
  assign laneTxEnOdd  = oddLanes;
  assign syncRestart  = anyLoss;
  assign ackTimerPause = anyLoss;
  assign ttlTimerRun  = 1'b1;
  assign evenPortNum  = {PAIR_IDX[1:0], 1'b0};
  assign oddPortNum   = {PAIR_IDX[1:0], 1'b1};

endmodule : dlst_pair
`default_nettype wire

// [dlst_pair_monitor.sv]
// Checker of the port-level relations of the port-pair supervision block
`timescale 1ns/1ps
`default_nettype none
module dlst_pair_monitor
  import dlst_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 nrst,
  input wire logic                 fabTxValid,
  input wire logic                 fabTxReady,
  input wire logic                 txPktReady,
  input wire logic                 rxPktValid,
  input wire logic                 rxFwdValid,
  input wire logic                 txFlush,
  input wire logic                 txFwdValid,
  input wire logic [1:0]           portErr,
  input wire logic [1:0]           portWriteReq,
  input wire logic [NUM_LANES-1:0] laneTxEnEven,
  input wire logic [NUM_LANES-1:0] laneTxEnOdd,
  input wire logic                 syncRestart,
  input wire logic                 ackTimerPause,
  input wire logic [2:0]           evenPortNum,
  input wire logic [2:0]           oddPortNum
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence pwOnce; ##1 !portWriteReq[0]; endsequence
  // Error flags may land up to two edges after the flush starts
  sequence bothErr; ##[0:2] portErr == 2'h3; endsequence
  fab_accept_a: assert property (fabTxReady)
    else $error("fabric stalled");
  fab_drop_a: assert property (txFwdValid == (fabTxValid && !txFlush))
    else $error("fabric traffic after expiry");
  rx_pass_a: assert property (rxFwdValid == rxPktValid)
    else $error("receive path blocked");
  tx_drain_a: assert property (txFlush |-> txPktReady)
    else $error("transmit buffer kept");
  dead_err_a: assert property ($rose(txFlush) |-> bothErr)
    else $error("expiry without both errors");
  pw_pulse_a: assert property (portWriteReq[0] |-> pwOnce)
    else $error("port write not a pulse");
  pw_cause_a: assert property (portWriteReq[1] |-> ##[0:1] portErr[1])
    else $error("port write without error");
  lane_map_a: assert property ({laneTxEnEven, laneTxEnOdd} inside {8'hf0, 8'h12})
    else $error("lane map wrong");
  sync_pause_a: assert property (syncRestart == ackTimerPause)
    else $error("ack timer not paused");
  port_num_a: assert property (!evenPortNum[0] && oddPortNum == evenPortNum + 3'h1)
    else $error("port numbers unpaired");
endmodule : dlst_pair_monitor
bind dlst_pair dlst_pair_monitor dlst_pair_monitor_inst (.clk_sys, .nrst, .fabTxValid,
  .fabTxReady, .txPktReady, .rxPktValid, .rxFwdValid, .txFlush, .txFwdValid, .portErr,
  .portWriteReq, .laneTxEnEven, .laneTxEnOdd, .syncRestart, .ackTimerPause, .evenPortNum,
  .oddPortNum);
`default_nettype wire

// [dlst_link_model.sv]
// Link partner stand-in: symbol clock, lane sync levels, init status
`timescale 1ns/1ps
`default_nettype none
module dlst_link_model (
  input  wire logic       run,
  input  wire logic       linkUp,
  input  wire logic [3:0] lossMask,
  output logic            symClk,
  output logic [3:0]      laneSync,
  output logic            linkInitDone
);
  // Clock stands still while run is low, whatever linkUp is
  initial symClk = 1'b0;
  always #80 if (run) symClk = ~symClk;
  assign laneSync     = ~lossMask;
  assign linkInitDone = linkUp;
endmodule : dlst_link_model
`default_nettype wire

// [testbench.sv]
// Self-checking bench of the port-pair supervision block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dlst_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        run = 1'b0;
  logic        linkUp = 1'b0;
  logic        pwClr = 1'b1;
  logic [3:0]  lossMask = 4'h0;
  logic [1:0]  regAddr = 2'h0;
  logic [31:0] regWdata = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        fabTxValid = 1'b0;
  logic        rxPktValid = 1'b0;
  logic        symClk, linkInitDone, fabTxReady, txPktReady, rxFwdValid, txFlush;
  logic        txFwdValid, syncRestart, ackTimerPause, ttlTimerRun;
  logic [3:0]  laneSync, laneTxEnEven, laneTxEnOdd;
  logic [1:0]  portErr, portWriteReq, pwSeen;
  logic [2:0]  evenPortNum, oddPortNum;
  logic [31:0] regRdata;
  int          error_cnt = 0;
  int          checked = 0;
  // Short lane and dead-link counts keep the run brief
  dlst_pair #(.LST_MAX(20'h10), .BASE_SH(2), .PAIR_IDX(3'h1)) dlst_pair_inst (.clk_sys, .nrst,
    .symClk, .laneSync, .linkInitDone, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .fabTxValid, .fabTxReady, .txPktValid(1'b1), .txPktReady, .rxPktValid, .rxFwdValid,
    .txFlush, .txFwdValid, .portErr, .portWriteReq, .laneTxEnEven, .laneTxEnOdd,
    .syncRestart, .ackTimerPause, .ttlTimerRun, .evenPortNum, .oddPortNum);
  dlst_link_model dlst_link_model_inst (.run, .linkUp, .lossMask, .symClk, .laneSync,
    .linkInitDone);
  always @(posedge clk_sys) pwSeen <= pwClr ? 2'h0 : pwSeen | portWriteReq;
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic acc(input logic rdN, input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= !rdN;
    regRd    <= rdN;
    @(posedge clk_sys);
    {regWr, regRd} <= 2'b00;
    if (rdN) begin
      // Read data stand only in the cycle after the strobe
      @(posedge clk_sys);
      chk("read data", regRdata, d);
    end
  endtask : acc
  task automatic clr(input logic [31:0] d);
    acc(1'b0, ADDR_CTRL, d);
    pwClr <= 1'b1;
    @(posedge clk_sys);
    pwClr <= 1'b0;
  endtask : clr
  task automatic ticks(input int n);
    repeat (n * 32) @(posedge clk_sys);
  endtask : ticks
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  initial begin
    #200_000;
    error_cnt++;
    conclude();
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst  <= 1'b1;
    pwClr <= 1'b0;
    acc(1'b1, ADDR_CTRL, 32'h7);
    acc(1'b1, ADDR_STAT, 32'h0);
    acc(1'b1, 2'h3, 32'h0);
    acc(1'b1, ADDR_PORTNUM, 32'h32);
    chk("port numbers", {evenPortNum, oddPortNum}, 6'h13);
    chk("lanes 4x", {laneTxEnEven, laneTxEnOdd}, 8'hf0);
    chk("ttl run", ttlTimerRun, 1'b1);
    run      <= 1'b1;
    lossMask <= 4'h1;
    ticks(20);
    chk("error before init", portErr, 2'h0);
    chk("sync restart", {syncRestart, ackTimerPause}, 2'h3);
    $display("test reset done");
    lossMask <= 4'h0;
    linkUp   <= 1'b1;
    clr(32'h10); // odd port left idle in four-lane mode
    ticks(2);
    acc(1'b1, ADDR_STAT, 32'h4);
    lossMask <= 4'h1;
    ticks(6);
    chk("disabled timer", {portErr, txFlush}, 3'h0);
    $display("test disabled done");
    acc(1'b0, ADDR_CTRL, 32'h11);
    ticks(6);
    chk("dead errors", portErr, 2'h3);
    chk("port writes", pwSeen, 2'h3);
    chk("flush", {txFlush, txPktReady}, 2'h3);
    fabTxValid <= 1'b1;
    rxPktValid <= 1'b1;
    @(posedge clk_sys);
    chk("fabric", {fabTxReady, txFwdValid, rxFwdValid}, 3'h5);
    acc(1'b1, ADDR_STAT, 32'hb);
    lossMask   <= 4'h0;
    fabTxValid <= 1'b0;
    ticks(1);
    clr(32'h310);
    acc(1'b1, ADDR_STAT, 32'h4);
    $display("test dead link done");
    lossMask <= 4'h8;
    ticks(14);
    chk("lane early", portErr, 2'h0);
    ticks(5);
    chk("lane expiry", {portErr, pwSeen}, 4'h5);
    lossMask <= 4'h0;
    ticks(1);
    clr(32'h330);
    chk("lanes 1x", {laneTxEnEven, laneTxEnOdd}, 8'h12);
    lossMask <= 4'h2;
    ticks(19);
    chk("odd expiry", portErr, 2'h3);
    $display("test lane sync done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
